// File: core/swlc_top.sv
// serial word link: control register, one transmitter, two receivers
// assumes an avalon-mm master and synchronous line-level digital inputs
//
// Chosen here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module swlc_top #(
    parameter int FAST_DIV = swlc_pkg::DIV_FAST,
    parameter int SLOW_DIV = swlc_pkg::DIV_SLOW,
    parameter int FIFO_DEPTH = swlc_pkg::TX_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // transmitter digital outputs
    output logic tx_digital_out_hi,
    output logic tx_digital_out_lo,
    // receiver digital inputs
    input wire logic rx1_in_hi,
    input wire logic rx1_in_lo,
    input wire logic rx2_in_hi,
    input wire logic rx2_in_lo
);
    localparam int LW = $clog2(FIFO_DEPTH+1);

    typedef struct packed {
        swlc_pkg::swlc_tx_state_t tx_state;
        logic [15:0] control;
        logic waitrequest;
        logic [31:0] readdata;
        logic [31:0] tx_word;
        logic [4:0] tx_idx;
        logic tx_half;
        logic [3:0] gap_cnt;
        logic tx_hi;
        logic tx_lo;
        logic [1:0][31:0] rx_shift;
        logic [1:0][5:0] rx_cnt;
        logic [1:0][11:0] rx_idle;
        logic [1:0] prev_hi;
        logic [1:0] prev_lo;
        logic [1:0][31:0] rx_word;
        logic [1:0] rx_ready;
    } swlc_state_t;

    localparam swlc_state_t SWLC_RESET = '{
        tx_state: swlc_pkg::TX_IDLE,
        control: swlc_pkg::CONTROL_RESET,
        waitrequest: 1'b1,
        default: '0
    };

    swlc_state_t q;
    swlc_state_t d;

    logic fifo_push;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [31:0] fifo_out_data;
    logic [LW-1:0] fifo_level;
    logic timer_restart;
    logic half_tick;
    logic [31:0] rd_mux;
    logic [31:0] load_word;
    logic [1:0] rx_hi;
    logic [1:0] rx_lo;
    logic [1:0] rx_en;
    logic [1:0] rx_m9;
    logic [1:0] rx_m10;
    logic [1:0] rx_slow;
    logic [1:0] word_done;
    logic tx_stall;

    ////////////////////////////////////////////////////////////////////////////
    // submodules

    swlc_fifo #(
        .WIDTH(swlc_pkg::WORD_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data(avs_writedata),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data),
        .level(fifo_level)
    );

    swlc_bit_timer #(
        .FAST_DIV(FAST_DIV),
        .SLOW_DIV(SLOW_DIV)
    ) u_timer (
        .clk(clk),
        .sys_rst(sys_rst),
        .restart(timer_restart),
        .slow(q.control[swlc_pkg::BIT_TX_RATE_SELECT]),
        .half_tick(half_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // control decode

    // self-test low feeds both receivers from the transmitter flops
    assign rx_hi = q.control[swlc_pkg::BIT_SELF_TEST_N] ? {rx2_in_hi, rx1_in_hi}
                                                        : {2{q.tx_hi}};
    assign rx_lo = q.control[swlc_pkg::BIT_SELF_TEST_N] ? {rx2_in_lo, rx1_in_lo}
                                                        : {2{q.tx_lo}};
    assign rx_en = {q.control[swlc_pkg::BIT_RX2_DECODER_ENABLE],
                    q.control[swlc_pkg::BIT_RX1_DECODER_ENABLE]};
    assign rx_m9 = {q.control[swlc_pkg::BIT_RX2_MATCH_BIT9],
                    q.control[swlc_pkg::BIT_RX1_MATCH_BIT9]};
    assign rx_m10 = {q.control[swlc_pkg::BIT_RX2_MATCH_BIT10],
                     q.control[swlc_pkg::BIT_RX1_MATCH_BIT10]};
    assign rx_slow = {q.control[swlc_pkg::BIT_RX2_RATE_SELECT],
                      q.control[swlc_pkg::BIT_RX1_RATE_SELECT]};

    // full fifo holds the bus in wait instead of dropping the word
    assign tx_stall = avs_write && (avs_address == swlc_pkg::OFS_TX_WORD) && !fifo_in_ready;
    assign fifo_push = !q.waitrequest && avs_write && (avs_address == swlc_pkg::OFS_TX_WORD);

    always_comb begin
        load_word = fifo_out_data;
        if (q.control[swlc_pkg::BIT_TX_BIT32_SELECT]) begin
            load_word[swlc_pkg::IDX_BIT32] = ~(^fifo_out_data[30:0])
                                           ^ q.control[swlc_pkg::BIT_TX_PARITY_INVERT];
        end
    end

    always_comb begin
        rd_mux = '0;
        case (avs_address)
            swlc_pkg::OFS_CONTROL: begin
                rd_mux[15:0] = q.control;
            end
            swlc_pkg::OFS_STATUS: begin
                rd_mux[swlc_pkg::ST_TX_EMPTY] = !fifo_out_valid;
                rd_mux[swlc_pkg::ST_TX_FULL] = !fifo_in_ready;
                rd_mux[swlc_pkg::ST_TX_BUSY] = q.tx_state != swlc_pkg::TX_IDLE;
                rd_mux[swlc_pkg::ST_RX1_READY] = q.rx_ready[0];
                rd_mux[swlc_pkg::ST_RX2_READY] = q.rx_ready[1];
                rd_mux[swlc_pkg::ST_TX_LEVEL_LSB +: LW] = fifo_level;
            end
            swlc_pkg::OFS_RX1_WORD: begin
                rd_mux = q.rx_word[0];
            end
            swlc_pkg::OFS_RX2_WORD: begin
                rd_mux = q.rx_word[1];
            end
            default: begin
                rd_mux = '0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic [31:0] shifted;
        logic edge_hi;
        logic edge_lo;
        logic [11:0] idle_lim;
        shifted = '0;
        edge_hi = 1'b0;
        edge_lo = 1'b0;
        idle_lim = '0;
        d = q;
        fifo_pop = 1'b0;
        timer_restart = 1'b0;
        word_done = '0;

        // bus: one wait cycle unless a tx word write stalls on a full fifo, answer in the cycle after
        if (q.waitrequest) begin
            if ((avs_read || avs_write) && !tx_stall) begin
                d.waitrequest = 1'b0;
                d.readdata = rd_mux;
            end
        end else begin
            d.waitrequest = 1'b1;
            if (avs_write && avs_address == swlc_pkg::OFS_CONTROL) begin
                if (avs_byteenable[0]) begin
                    d.control[7:0] = avs_writedata[7:0];
                end
                if (avs_byteenable[1]) begin
                    d.control[15:8] = avs_writedata[15:8];
                end
            end
            // clear first, so a word landing now sets it again below
            if (avs_read && avs_address == swlc_pkg::OFS_RX1_WORD) begin
                d.rx_ready[0] = 1'b0;
            end
            if (avs_read && avs_address == swlc_pkg::OFS_RX2_WORD) begin
                d.rx_ready[1] = 1'b0;
            end
        end

        // transmitter
        case (q.tx_state)
            swlc_pkg::TX_IDLE: begin
                timer_restart = 1'b1;
                if (fifo_out_valid) begin
                    fifo_pop = 1'b1;
                    d.tx_word = load_word;
                    d.tx_idx = '0;
                    d.tx_half = 1'b0;
                    d.tx_state = swlc_pkg::TX_SEND;
                end
            end
            swlc_pkg::TX_SEND: begin
                if (half_tick) begin
                    if (!q.tx_half) begin
                        d.tx_half = 1'b1;
                    end else begin
                        d.tx_half = 1'b0;
                        if (q.tx_idx == 5'd31) begin
                            d.tx_state = swlc_pkg::TX_GAP;
                            d.gap_cnt = '0;
                        end else begin
                            d.tx_idx = q.tx_idx + 5'd1;
                        end
                    end
                end
            end
            swlc_pkg::TX_GAP: begin
                if (half_tick) begin
                    if (q.gap_cnt == 4'(2 * swlc_pkg::TX_GAP_BITS - 1)) begin
                        d.tx_state = swlc_pkg::TX_IDLE;
                    end else begin
                        d.gap_cnt = q.gap_cnt + 4'h1;
                    end
                end
            end
            default: begin
                d.tx_state = swlc_pkg::TX_IDLE;
            end
        endcase
        // first half of each bit drives one line, second half is null
        d.tx_hi = (d.tx_state == swlc_pkg::TX_SEND) && !d.tx_half && d.tx_word[d.tx_idx];
        d.tx_lo = (d.tx_state == swlc_pkg::TX_SEND) && !d.tx_half && !d.tx_word[d.tx_idx];

        // receivers: a rising line edge is one bit, silence drops a partial word
        for (int i = 0; i < 2; i++) begin
            d.prev_hi[i] = rx_hi[i];
            d.prev_lo[i] = rx_lo[i];
            edge_hi = rx_hi[i] && !q.prev_hi[i];
            edge_lo = rx_lo[i] && !q.prev_lo[i];
            idle_lim = rx_slow[i] ? 12'(swlc_pkg::RX_TIMEOUT_BITS * SLOW_DIV)
                                  : 12'(swlc_pkg::RX_TIMEOUT_BITS * FAST_DIV);
            shifted = {edge_hi, q.rx_shift[i][31:1]};
            if (edge_hi || edge_lo) begin
                d.rx_idle[i] = '0;
                if (q.rx_cnt[i] == 6'd31) begin
                    d.rx_cnt[i] = '0;
                    word_done[i] = 1'b1;
                    if (!rx_en[i]
                        || (shifted[swlc_pkg::IDX_BIT9] == rx_m9[i]
                            && shifted[swlc_pkg::IDX_BIT10] == rx_m10[i])) begin
                        d.rx_word[i] = shifted;
                        d.rx_ready[i] = 1'b1;
                    end
                end else begin
                    d.rx_shift[i] = shifted;
                    d.rx_cnt[i] = q.rx_cnt[i] + 6'd1;
                end
            end else if (q.rx_cnt[i] != '0) begin
                if (q.rx_idle[i] == idle_lim - 12'h001) begin
                    d.rx_cnt[i] = '0;
                    d.rx_idle[i] = '0;
                end else begin
                    d.rx_idle[i] = q.rx_idle[i] + 12'h001;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= SWLC_RESET;
        end else begin
            q <= d;
        end
    end

    assign avs_readdata = q.readdata;
    assign avs_waitrequest = q.waitrequest;
    assign tx_digital_out_hi = q.tx_hi;
    assign tx_digital_out_lo = q.tx_lo;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    logic [11:0] since_pulse;
    logic drive;
    assign drive = q.tx_hi || q.tx_lo;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            since_pulse <= '0;
        end else if (drive && !$past(drive)) begin
            since_pulse <= 12'h001;
        end else if (since_pulse != 12'hFFF) begin
            since_pulse <= since_pulse + 12'h001;
        end
    end

    sequence s_load;
        q.tx_state == swlc_pkg::TX_IDLE && fifo_out_valid;
    endsequence
    sequence s_fast_half;
        drive [*5] ##1 !drive;
    endsequence

    bit32_data_a: assert property ((s_load and !q.control[swlc_pkg::BIT_TX_BIT32_SELECT])
        |=> q.tx_word[31] == $past(fifo_out_data[31])) else $error("bit 32 not data");
    parity_odd_a: assert property ((s_load and (q.control[swlc_pkg::BIT_TX_BIT32_SELECT]
        && !q.control[swlc_pkg::BIT_TX_PARITY_INVERT])) |=> ^q.tx_word) else $error("not odd");
    parity_even_a: assert property ((s_load and (q.control[swlc_pkg::BIT_TX_BIT32_SELECT]
        && q.control[swlc_pkg::BIT_TX_PARITY_INVERT])) |=> !(^q.tx_word)) else $error("not even");
    loop_route_a: assert property (!q.control[swlc_pkg::BIT_SELF_TEST_N] && $rose(q.tx_hi)
        |=> q.prev_hi == 2'b11) else $error("loopback missing");
    rx1_open_a: assert property (word_done[0] && !rx_en[0] |=> q.rx_ready[0]
        && q.rx_word[0] == {$past(rx_hi[0] && !q.prev_hi[0]), $past(q.rx_shift[0][31:1])})
        else $error("rx1 dropped");
    rx1_match_a: assert property ($rose(q.rx_ready[0]) && rx_en[0]
        |-> q.rx_word[0][9:8] == {rx_m10[0], rx_m9[0]}) else $error("rx1 filter");
    rx2_match_a: assert property ($rose(q.rx_ready[1]) && rx_en[1]
        |-> q.rx_word[1][9:8] == {rx_m10[1], rx_m9[1]}) else $error("rx2 filter");
    tx_fast_half_a: assert property ($rose(drive) && !q.control[swlc_pkg::BIT_TX_RATE_SELECT]
        |-> s_fast_half) else $error("fast half bit wrong");
    tx_fast_rate_a: assert property ($rose(drive) && q.tx_idx != '0
        && !q.control[swlc_pkg::BIT_TX_RATE_SELECT] |-> since_pulse == 12'(FAST_DIV))
        else $error("fast bit period wrong");
    tx_slow_rate_a: assert property ($rose(drive) && q.tx_idx != '0
        && q.control[swlc_pkg::BIT_TX_RATE_SELECT] |-> since_pulse == 12'(SLOW_DIV))
        else $error("slow bit period wrong");
    rx2_fast_gap_a: assert property (q.rx_cnt[1] != '0 && !rx_slow[1]
        && q.rx_idle[1] == 12'(swlc_pkg::RX_TIMEOUT_BITS * FAST_DIV - 1) && word_done == '0
        && !(rx_hi[1] && !q.prev_hi[1]) && !(rx_lo[1] && !q.prev_lo[1])
        |=> q.rx_cnt[1] == '0) else $error("rx2 timeout wrong");
    bus_answer_a: assert property (!q.waitrequest |=> q.waitrequest) else $error("long answer");
endmodule

// File: pkg/swlc_pkg.sv
// constants and types shared by the serial word link configuration block
// assumes a single clock domain; divisors are counts of that clock
package swlc_pkg;

    // register byte offsets, one aligned 32-bit word each
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_TX_WORD = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_RX1_WORD = 8'h0C;
    localparam logic [7:0] OFS_RX2_WORD = 8'h10;

    // control register fields
    localparam int CTRL_W = 16;
    localparam int BIT_TX_BIT32_SELECT = 4;
    localparam int BIT_SELF_TEST_N = 5;
    localparam int BIT_RX1_DECODER_ENABLE = 6;
    localparam int BIT_RX1_MATCH_BIT9 = 7;
    localparam int BIT_RX1_MATCH_BIT10 = 8;
    localparam int BIT_RX2_DECODER_ENABLE = 9;
    localparam int BIT_RX2_MATCH_BIT9 = 10;
    localparam int BIT_RX2_MATCH_BIT10 = 11;
    localparam int BIT_TX_PARITY_INVERT = 12;
    localparam int BIT_TX_RATE_SELECT = 13;
    localparam int BIT_RX2_RATE_SELECT = 14;
    localparam int BIT_RX1_RATE_SELECT = 15;
    localparam logic [15:0] CONTROL_RESET = 16'h0020;

    // status register fields
    localparam int ST_TX_EMPTY = 0;
    localparam int ST_TX_FULL = 1;
    localparam int ST_TX_BUSY = 2;
    localparam int ST_RX1_READY = 3;
    localparam int ST_RX2_READY = 4;
    localparam int ST_TX_LEVEL_LSB = 8;

    // word layout: line bit n sits at index n-1, first bit on the line at index 0
    localparam int WORD_BITS = 32;
    localparam int IDX_BIT9 = 8;
    localparam int IDX_BIT10 = 9;
    localparam int IDX_BIT32 = 31;

    // timing: divisors in clock cycles, gap and timeout in bit periods
    localparam int DIV_FAST = 10;
    localparam int DIV_SLOW = 80;
    localparam int TX_GAP_BITS = 4;
    localparam int RX_TIMEOUT_BITS = 2;
    localparam int TX_FIFO_DEPTH = 8;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_SEND = 3'b010,
        TX_GAP = 3'b100
    } swlc_tx_state_t;

endpackage

// File: core/swlc_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes DEPTH is a power of two
`timescale 1ns/1ps
module swlc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // fill level
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [CW-1:0] count;
    } swlc_fifo_state_t;

    swlc_fifo_state_t q;
    swlc_fifo_state_t d;
    logic push;
    logic pop;

    assign in_ready = q.count != CW'(DEPTH);
    assign out_valid = q.count != '0;
    assign out_data = q.mem[q.rd_ptr];
    assign level = q.count;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wr_ptr] = in_data;
            d.wr_ptr = q.wr_ptr + AW'(1);
        end
        if (pop) begin
            d.rd_ptr = q.rd_ptr + AW'(1);
        end
        if (push && !pop) begin
            d.count = q.count + CW'(1);
        end else if (pop && !push) begin
            d.count = q.count - CW'(1);
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    count_bound_a: assert property (@(posedge clk) disable iff (sys_rst)
        q.count <= CW'(DEPTH)) else $error("fifo count above depth");
endmodule

// File: core/swlc_bit_timer.sv
// half-bit tick generator for the transmitter
// assumes divisors are even and at least two
`timescale 1ns/1ps
module swlc_bit_timer #(
    parameter int FAST_DIV = swlc_pkg::DIV_FAST,
    parameter int SLOW_DIV = swlc_pkg::DIV_SLOW
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // control
    input wire logic restart,
    input wire logic slow,
    // half-bit pulse
    output logic half_tick
);
    typedef struct packed {
        logic [11:0] cnt;
    } swlc_timer_state_t;

    swlc_timer_state_t q;
    swlc_timer_state_t d;
    logic [11:0] half_len;

    assign half_len = slow ? 12'(SLOW_DIV / 2) : 12'(FAST_DIV / 2);
    assign half_tick = !restart && (q.cnt == half_len - 12'h001);

    always_comb begin
        d = q;
        if (restart || half_tick) begin
            d.cnt = '0;
        end else begin
            d.cnt = q.cnt + 12'h001;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

// File: sim/swlc_line_model.sv
// serial line partner: decodes the transmitter, drives either receiver
// assumes synchronous digital line levels on the one clock
`timescale 1ns/1ps
module swlc_line_model (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // from transmitter
    input wire logic tx_hi,
    input wire logic tx_lo,
    // to receivers
    output logic rx1_hi,
    output logic rx1_lo,
    output logic rx2_hi,
    output logic rx2_lo
);
    logic [31:0] words[$];
    logic [31:0] acc = 32'h0;
    logic hi_q = 1'b0;
    logic lo_q = 1'b0;
    int nbit = 0;
    int per = 0;
    int since = 0;

    initial begin
        {rx1_hi, rx1_lo, rx2_hi, rx2_lo} = 4'h0;
    end

    ////////////////////////////////////////////////////////////////
    // a rising edge on either line is one bit; per is the edge spacing
    always @(posedge clk) begin
        hi_q <= tx_hi;
        lo_q <= tx_lo;
        since <= since + 1;
        if ((tx_hi && !hi_q) || (tx_lo && !lo_q)) begin
            per <= since + 1;
            since <= 0;
            acc[nbit] <= tx_hi;
            nbit <= (nbit == 31) ? 0 : nbit + 1;
            if (nbit == 31)
                words.push_back({tx_hi, acc[30:0]});
        end
        if (sys_rst)
            nbit <= 0;
    end

    ////////////////////////////////////////////////////////////////
    task automatic drive(input int r, input logic h, input logic l);
        @(posedge clk);
        rx1_hi <= (r == 1) && h;
        rx1_lo <= (r == 1) && l;
        rx2_hi <= (r == 2) && h;
        rx2_lo <= (r == 2) && l;
    endtask

    // null between words, so the receiver never sees a held level
    // fewer than 32 bits leaves a cut word for the receiver to drop
    task automatic send(input logic [31:0] w, input int div, input int r, input int nb = 32);
        for (int i = 0; i < nb; i++) begin
            repeat (div / 2) drive(r, w[i], !w[i]);
            repeat (div / 2) drive(r, 1'b0, 1'b0);
        end
        repeat (4 * div) drive(r, 1'b0, 1'b0);
    endtask
endmodule

// File: sim/testbench.sv
// self-checking bench for the serial word link block
// assumes the default divisors and an 8-deep transmit fifo
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic tx_hi, tx_lo, r1h, r1l, r2h, r2l;
    logic [31:0] rd = 32'h0;
    int error_cnt = 0;
    int tests_run = 0;
    int cycles = 0;

    always #25 clk = ~clk;

    swlc_top dut_u (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .tx_digital_out_hi(tx_hi),
        .tx_digital_out_lo(tx_lo), .rx1_in_hi(r1h), .rx1_in_lo(r1l),
        .rx2_in_hi(r2h), .rx2_in_lo(r2l));

    swlc_line_model model_u (.clk(clk), .sys_rst(sys_rst), .tx_hi(tx_hi), .tx_lo(tx_lo),
        .rx1_hi(r1h), .rx1_lo(r1l), .rx2_hi(r2h), .rx2_lo(r2l));

    ////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("compares %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ceiling well above the roughly 12k cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            error_cnt++;
            end_of_test();
        end
    end

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // request held until waitrequest is sampled low; no cycle count assumed
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wait_words(input int n);
        repeat (20000) begin
            if (model_u.words.size() >= n)
                break;
            @(posedge clk);
        end
    endtask

    ////////////////////////////////////////////////////////////////
    task automatic test_regs;
        bus(1'b0, swlc_pkg::OFS_CONTROL, 32'h0);
        cmp("control reset", {16'h0, swlc_pkg::CONTROL_RESET}, rd);
        bus(1'b1, swlc_pkg::OFS_CONTROL, 32'h0000_7FAF);
        bus(1'b0, swlc_pkg::OFS_CONTROL, 32'h0);
        cmp("control rw", 32'h0000_7FAF, rd);
        bus(1'b1, 8'h40, 32'hFFFF_FFFF);
        bus(1'b0, 8'h40, 32'h0);
        cmp("unmapped", 32'h0, rd);
        $display("test regs done");
    endtask

    task automatic tx_word(input logic [15:0] ctl, input logic [31:0] w,
            input logic [31:0] exp, input int per);
        bus(1'b1, swlc_pkg::OFS_CONTROL, {16'h0, ctl});
        bus(1'b1, swlc_pkg::OFS_TX_WORD, w);
        wait_words(1);
        cmp("tx word", exp, model_u.words.pop_front());
        cmp("bit period", per, model_u.per);
    endtask

    task automatic test_tx;
        logic [31:0] w;
        w = 32'h0123_4567;
        tx_word(16'h0020, 32'hC3A5_0F01, 32'hC3A5_0F01, 10);
        tx_word(16'h0030, w, {~^w[30:0], w[30:0]}, 10);
        tx_word(16'h3030, w, {^w[30:0], w[30:0]}, 80);
        w = 32'h8000_0003;
        tx_word(16'h0030, w, {~^w[30:0], w[30:0]}, 10);
        $display("test tx done");
    endtask

    // ninth word fills the fifo behind the word on the line; tenth must stall
    task automatic test_fifo;
        bus(1'b1, swlc_pkg::OFS_CONTROL, 32'h20);
        for (int i = 0; i < 9; i++)
            bus(1'b1, swlc_pkg::OFS_TX_WORD, 32'h1111_1111 * i);
        bus(1'b0, swlc_pkg::OFS_STATUS, 32'h0);
        cmp("fifo full", 32'h1, {31'h0, rd[swlc_pkg::ST_TX_FULL]});
        cmp("fifo level", 32'h8, {28'h0, rd[11:8]});
        bus(1'b1, swlc_pkg::OFS_TX_WORD, 32'hFFFF_FFFF);
        wait_words(10);
        for (int i = 0; i < 9; i++)
            cmp("fifo order", 32'h1111_1111 * i, model_u.words.pop_front());
        cmp("fifo last", 32'hFFFF_FFFF, model_u.words.pop_front());
        bus(1'b0, swlc_pkg::OFS_STATUS, 32'h0);
        cmp("fifo empty", 32'h1, {31'h0, rd[swlc_pkg::ST_TX_EMPTY]});
        $display("test fifo done");
    endtask

    task automatic test_rx(input int r, input logic [15:0] on, input logic [7:0] ofs, input int rb);
        bus(1'b1, swlc_pkg::OFS_CONTROL, 32'h20);
        model_u.send(32'h1234_5200, 10, r);
        bus(1'b0, swlc_pkg::OFS_STATUS, 32'h0);
        cmp("rx ready", 32'h1, {31'h0, rd[rb]});
        bus(1'b0, ofs, 32'h0);
        cmp("rx word open", 32'h1234_5200, rd);
        bus(1'b1, swlc_pkg::OFS_CONTROL, {16'h0, on});
        model_u.send(32'h1234_5200, 10, r);
        bus(1'b0, swlc_pkg::OFS_STATUS, 32'h0);
        cmp("rx rejected", 32'h0, {31'h0, rd[rb]});
        model_u.send(32'hFFFF_FFFF, 10, r, 20);
        model_u.send(32'h1234_5100, 10, r);
        bus(1'b0, ofs, 32'h0);
        cmp("rx word match", 32'h1234_5100, rd);
        $display("test rx%0d done", r);
    endtask

    // loopback: pins stay idle, both receivers must still see the word
    task automatic test_self;
        bus(1'b1, swlc_pkg::OFS_CONTROL, 32'h0);
        bus(1'b1, swlc_pkg::OFS_TX_WORD, 32'h0F0F_3C3C);
        rd = 32'h0;
        for (int i = 0; i < 400 && rd[swlc_pkg::ST_RX2_READY] !== 1'b1; i++)
            bus(1'b0, swlc_pkg::OFS_STATUS, 32'h0);
        bus(1'b0, swlc_pkg::OFS_RX1_WORD, 32'h0);
        cmp("loop rx1", 32'h0F0F_3C3C, rd);
        bus(1'b0, swlc_pkg::OFS_RX2_WORD, 32'h0);
        cmp("loop rx2", 32'h0F0F_3C3C, rd);
        $display("test self done");
    endtask

    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        test_regs();
        test_tx();
        test_fifo();
        test_rx(1, 16'h00E0, swlc_pkg::OFS_RX1_WORD, swlc_pkg::ST_RX1_READY);
        test_rx(2, 16'h0620, swlc_pkg::OFS_RX2_WORD, swlc_pkg::ST_RX2_READY);
        test_self();
        end_of_test();
    end
endmodule
